/* File: pcm_stage_pkg.sv */
package pcm_stage_pkg;

  // ************************************************************
  // Word layout
  // ************************************************************
  localparam int WORD_BITS = 6;
  localparam int MSB_POS = 5;
  localparam int LSB_POS = 0;
  localparam logic [5:0] CODE_SUBTRACT = 6'h0f; // Code 15
  localparam logic [5:0] CODE_ADD = 6'h30; // Code 48
  localparam logic [2:0] BITS_PER_WORD = 3'h6;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] COUNT_ADDR = 4'h8;

  // CTRL fields
  localparam int MODE_BIT = 0;
  localparam int DELAY_LO = 4;
  localparam int DELAY_W = 4;
  localparam logic [3:0] DELAY_RESET = 4'h2;
  localparam logic [3:0] DELAY_ONE = 4'h1;

  // STATUS fields
  localparam int ST_WORD_LO = 0;
  localparam int ST_SUB_BIT = 6;
  localparam int ST_ADD_BIT = 7;
  localparam int ST_SPACE_BIT = 8;

  localparam int COUNT_W = 16;

  // ************************************************************
  // Link strobe sequencer
  // ************************************************************
  typedef enum logic [1:0] {
    STB_IDLE,
    STB_DELAY,
    STB_PULSE
  } strobe_state_e;

endpackage : pcm_stage_pkg

/* File: pcm_word_parallel_stage.sv */
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ns
module pcm_word_parallel_stage (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic link_clk,
  input wire logic word_pulse,
  input wire logic last_channel_n,
  input wire logic [5:0] serial_word,
  output logic [5:0] ladder_drive,
  output logic msb_ref,
  output logic msb_gnd,
  output logic subtract_half_bit,
  output logic add_half_bit
);

  // ************************************************************
  // Software registers (system clock)
  // ************************************************************
  logic traffic_mode_select_reg;
  logic [3:0] delay_cfg_reg;
  logic space_err_reg;
  logic [15:0] xfer_count_reg;
  logic [5:0] held_word_reg;
  logic held_sub_reg;
  logic held_add_reg;
  logic new_word_pulse;
  logic space_err_pulse;

  // Code match used for both correction bits
  function automatic logic code_is(input logic [5:0] word, input logic [5:0] code);
    code_is = (word == code);
  endfunction : code_is

  // Control register writes; mode and delay are steady levels seen by the link side
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      traffic_mode_select_reg <= 1'b0;
      delay_cfg_reg <= pcm_stage_pkg::DELAY_RESET;
    end else if (ce && wr_en && addr == pcm_stage_pkg::CTRL_ADDR) begin
      traffic_mode_select_reg <= wdata[pcm_stage_pkg::MODE_BIT];
      delay_cfg_reg <= wdata[pcm_stage_pkg::DELAY_LO +: pcm_stage_pkg::DELAY_W];
    end
  end

  // Sticky spacing error; a new event wins over a clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      space_err_reg <= 1'b0;
    end else if (ce) begin
      if (space_err_pulse) begin
        space_err_reg <= 1'b1;
      end else if (wr_en && addr == pcm_stage_pkg::STATUS_ADDR
                   && wdata[pcm_stage_pkg::ST_SPACE_BIT]) begin
        space_err_reg <= 1'b0;
      end
    end
  end

  // Count of transfers seen, wraps
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xfer_count_reg <= 16'h0000;
    end else if (ce && new_word_pulse) begin
      xfer_count_reg <= xfer_count_reg + 16'h0001;
    end
  end

  // Read data valid only in the cycle after the read strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= 32'h0000_0000;
      if (rd_en) begin
        case (addr)
          pcm_stage_pkg::CTRL_ADDR: begin
            rdata[pcm_stage_pkg::MODE_BIT] <= traffic_mode_select_reg;
            rdata[pcm_stage_pkg::DELAY_LO +: pcm_stage_pkg::DELAY_W] <= delay_cfg_reg;
          end
          pcm_stage_pkg::STATUS_ADDR: begin
            rdata[pcm_stage_pkg::ST_WORD_LO +: pcm_stage_pkg::WORD_BITS] <= held_word_reg;
            rdata[pcm_stage_pkg::ST_SUB_BIT] <= held_sub_reg;
            rdata[pcm_stage_pkg::ST_ADD_BIT] <= held_add_reg;
            rdata[pcm_stage_pkg::ST_SPACE_BIT] <= space_err_reg;
          end
          pcm_stage_pkg::COUNT_ADDR: begin
            rdata[pcm_stage_pkg::COUNT_W-1:0] <= xfer_count_reg;
          end
          default: begin
            rdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Link domain reset and level crossings
  // ************************************************************
  logic link_rst_meta;
  logic link_rst;
  logic mode_meta;
  logic high_traffic_mode;
  logic [3:0] delay_meta;
  logic [3:0] delay_sync;
  logic ce_meta;
  logic link_ce;

  // Reset asserts at once, releases on the link clock
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_rst_meta <= 1'b1;
      link_rst <= 1'b1;
    end else begin
      link_rst_meta <= 1'b0;
      link_rst <= link_rst_meta;
    end
  end

  // Config is quasi-static; change it only between frames to avoid a torn delay value
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      mode_meta <= 1'b0;
      high_traffic_mode <= 1'b0;
      delay_meta <= pcm_stage_pkg::DELAY_RESET;
      delay_sync <= pcm_stage_pkg::DELAY_RESET;
      ce_meta <= 1'b0;
      link_ce <= 1'b0;
    end else begin
      mode_meta <= traffic_mode_select_reg;
      high_traffic_mode <= mode_meta;
      delay_meta <= delay_cfg_reg;
      delay_sync <= delay_meta;
      ce_meta <= ce;
      link_ce <= ce_meta;
    end
  end

  // ************************************************************
  // Transfer strobe generation (link clock)
  // ************************************************************
  pcm_stage_pkg::strobe_state_e stb_state_reg;
  logic word_pulse_prev_reg;
  logic [3:0] delay_cnt_reg;
  logic word_fall;

  // Word pulse and serial word come from logic on this clock, so no synchroniser
  assign word_fall = word_pulse_prev_reg && !word_pulse;

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      word_pulse_prev_reg <= 1'b0;
    end else if (link_ce) begin
      word_pulse_prev_reg <= word_pulse;
    end
  end

  // Strobe sequencer; the load happens as the one-cycle strobe ends
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      stb_state_reg <= pcm_stage_pkg::STB_IDLE;
      delay_cnt_reg <= 4'h0;
    end else if (link_ce) begin
      case (stb_state_reg)
        pcm_stage_pkg::STB_IDLE: begin
          if (word_fall && high_traffic_mode) begin
            stb_state_reg <= pcm_stage_pkg::STB_DELAY;
            delay_cnt_reg <= (delay_sync == 4'h0) ? pcm_stage_pkg::DELAY_ONE : delay_sync;
          end else if (word_fall) begin
            stb_state_reg <= pcm_stage_pkg::STB_PULSE;
          end
        end
        pcm_stage_pkg::STB_DELAY: begin
          if (delay_cnt_reg <= pcm_stage_pkg::DELAY_ONE) begin
            stb_state_reg <= pcm_stage_pkg::STB_PULSE;
          end else begin
            delay_cnt_reg <= delay_cnt_reg - 4'h1;
          end
        end
        pcm_stage_pkg::STB_PULSE: begin
          stb_state_reg <= pcm_stage_pkg::STB_IDLE;
        end
        default: begin
          stb_state_reg <= pcm_stage_pkg::STB_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Holding register and correction bits (link clock)
  // ************************************************************
  logic strobe_end;
  logic lsb_load;
  logic lsb_clear;
  logic [5:0] link_hold_reg;
  logic link_sub_reg;
  logic link_add_reg;
  logic link_toggle_reg;

  assign strobe_end = (stb_state_reg == pcm_stage_pkg::STB_PULSE);
  // Last-channel marker steers the lsb stage between load and clear
  assign lsb_load = strobe_end && last_channel_n;
  assign lsb_clear = strobe_end && !last_channel_n;

  // Upper stages copy straight across, msb from the last serial stage
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      link_hold_reg[pcm_stage_pkg::MSB_POS:pcm_stage_pkg::LSB_POS+1] <= 5'h00;
    end else if (link_ce && strobe_end) begin
      link_hold_reg[pcm_stage_pkg::MSB_POS:pcm_stage_pkg::LSB_POS+1] <=
        serial_word[pcm_stage_pkg::MSB_POS:pcm_stage_pkg::LSB_POS+1];
    end
  end

  // Lsb stage: a synchronous clear stands in for the old direct clear
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      link_hold_reg[pcm_stage_pkg::LSB_POS] <= 1'b0;
    end else if (link_ce) begin
      if (lsb_clear) begin
        link_hold_reg[pcm_stage_pkg::LSB_POS] <= 1'b0;
      end else if (lsb_load) begin
        link_hold_reg[pcm_stage_pkg::LSB_POS] <= serial_word[pcm_stage_pkg::LSB_POS];
      end
    end
  end

  // Correction bits: subtract set on code 15, add cleared on code 48, idle otherwise
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      link_sub_reg <= 1'b0;
      link_add_reg <= 1'b1;
    end else if (link_ce && strobe_end) begin
      link_sub_reg <= code_is(serial_word, pcm_stage_pkg::CODE_SUBTRACT);
      link_add_reg <= !code_is(serial_word, pcm_stage_pkg::CODE_ADD);
    end
  end

  // Toggle marks a new word; data then stands a whole word period, well past the sync delay
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      link_toggle_reg <= 1'b0;
    end else if (link_ce && strobe_end) begin
      link_toggle_reg <= !link_toggle_reg;
    end
  end

  // ************************************************************
  // Transfer spacing check (link clock)
  // ************************************************************
  logic [2:0] space_cnt_reg;
  logic space_seen_reg;
  logic space_toggle_reg;

  // Counts bit clocks between strobes; a wrong count raises an event
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      space_cnt_reg <= 3'h0;
      space_seen_reg <= 1'b0;
      space_toggle_reg <= 1'b0;
    end else if (link_ce) begin
      if (strobe_end) begin
        space_cnt_reg <= 3'h1;
        space_seen_reg <= 1'b1;
        if (space_seen_reg && space_cnt_reg != pcm_stage_pkg::BITS_PER_WORD) begin
          space_toggle_reg <= !space_toggle_reg;
        end
      end else if (space_cnt_reg != 3'h7) begin
        space_cnt_reg <= space_cnt_reg + 3'h1;
      end
    end
  end

  // ************************************************************
  // Event crossings into the system clock
  // ************************************************************
  logic word_tog_meta;
  logic word_tog_sync;
  logic word_tog_prev;
  logic space_tog_meta;
  logic space_tog_sync;
  logic space_tog_prev;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_tog_meta <= 1'b0;
      word_tog_sync <= 1'b0;
      space_tog_meta <= 1'b0;
      space_tog_sync <= 1'b0;
    end else begin
      word_tog_meta <= link_toggle_reg;
      word_tog_sync <= word_tog_meta;
      space_tog_meta <= space_toggle_reg;
      space_tog_sync <= space_tog_meta;
    end
  end

  // Edge memory is frozen with the rest so no event is dropped while ce is low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_tog_prev <= 1'b0;
      space_tog_prev <= 1'b0;
    end else if (ce) begin
      word_tog_prev <= word_tog_sync;
      space_tog_prev <= space_tog_sync;
    end
  end

  assign new_word_pulse = word_tog_sync ^ word_tog_prev;
  assign space_err_pulse = space_tog_sync ^ space_tog_prev;

  // ************************************************************
  // Ladder drive outputs (system clock)
  // ************************************************************
  // Held copy of the word for read back; the ladder flops load link_hold_reg themselves
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      held_word_reg <= 6'h00;
      held_sub_reg <= 1'b0;
      held_add_reg <= 1'b1;
    end else if (ce && new_word_pulse) begin
      held_word_reg <= link_hold_reg;
      held_sub_reg <= link_sub_reg;
      held_add_reg <= link_add_reg;
    end
  end

  // One flop per ladder step, index equals binary weight position
  genvar g;
  generate
    for (g = 0; g < pcm_stage_pkg::WORD_BITS; g++) begin : g_ladder
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          ladder_drive[g] <= 1'b0;
        end else if (ce && new_word_pulse) begin
          ladder_drive[g] <= link_hold_reg[g];
        end
      end
    end
  endgenerate

  // Complementary msb pair, loaded together so they never agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      msb_ref <= 1'b0;
      msb_gnd <= 1'b1;
    end else if (ce && new_word_pulse) begin
      msb_ref <= link_hold_reg[pcm_stage_pkg::MSB_POS];
      msb_gnd <= !link_hold_reg[pcm_stage_pkg::MSB_POS];
    end
  end

  // Half-step correction outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      subtract_half_bit <= 1'b0;
      add_half_bit <= 1'b1;
    end else if (ce && new_word_pulse) begin
      subtract_half_bit <= link_sub_reg;
      add_half_bit <= link_add_reg;
    end
  end

endmodule : pcm_word_parallel_stage

/* File: pcm_stage_chk.sv */
`timescale 1ns/1ns
module pcm_stage_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic [5:0] ladder_drive,
  input wire logic msb_ref,
  input wire logic msb_gnd,
  input wire logic subtract_half_bit,
  input wire logic add_half_bit
);
  // ********
  // Output checks
  // ********
  // Only the system domain is watched, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  msb_pair_a: assert property (msb_gnd != msb_ref)
    else $error("msb outputs not complementary");
  msb_step_a: assert property (msb_ref == ladder_drive[5])
    else $error("msb step differs from held msb");
  corr_combo_a: assert property (subtract_half_bit |-> add_half_bit)
    else $error("both corrections active");
  sub_code_a: assert property (subtract_half_bit |-> ladder_drive[5:1] == 5'h07)
    else $error("subtract bit without code 15");
  add_code_a: assert property (!add_half_bit |-> ladder_drive == 6'h30)
    else $error("add bit without code 48");
  rst_val_a: assert property ($fell(sys_rst) |->
    ladder_drive == 6'h00 && msb_gnd && !subtract_half_bit && add_half_bit)
    else $error("wrong output after reset");
  // A word must stand for far longer than eight cycles of this clock
  hold_stable_a: assert property ($changed(ladder_drive) |=> $stable(ladder_drive) [*8])
    else $error("held word changed too soon");
  status_word_a: assert property ($past(rd_en && ce) &&
    $past(addr) == pcm_stage_pkg::STATUS_ADDR |->
    rdata[5:0] == $past(ladder_drive) || rdata[5:0] == ladder_drive)
    else $error("status word differs from held word");

  sub_seen_c: cover property ($rose(subtract_half_bit));
  add_seen_c: cover property ($fell(add_half_bit));
  lsb_clr_c: cover property ($fell(ladder_drive[0]) && ladder_drive[5]);
endmodule : pcm_stage_chk

bind pcm_word_parallel_stage pcm_stage_chk chk (.clk(clk), .sys_rst(sys_rst), .ce(ce),
  .addr(addr), .rd_en(rd_en), .rdata(rdata), .ladder_drive(ladder_drive),
  .msb_ref(msb_ref), .msb_gnd(msb_gnd), .subtract_half_bit(subtract_half_bit),
  .add_half_bit(add_half_bit));

/* File: pcm_timing_model.sv */
`timescale 1ns/1ns
module pcm_timing_model (
  input wire logic link_clk,
  input wire logic run,
  input wire logic [5:0] word_in,
  input wire logic last_in,
  input wire logic [2:0] lead,
  output logic [2:0] slot_pos,
  output logic word_pulse,
  output logic last_channel_n,
  output logic [5:0] serial_word
);
  logic [2:0] fall_pos;

  // Fall placed so the load lands just before the next word's first shift
  assign fall_pos = 3'h6 - lead;

  initial begin
    slot_pos = 3'h0;
    word_pulse = 1'b1;
    last_channel_n = 1'b1;
    serial_word = 6'h2a;
  end

  // One chain gives six bit clocks per word pulse; shifting never pauses
  always @(posedge link_clk) begin
    slot_pos <= (slot_pos == 3'h5) ? 3'h0 : slot_pos + 3'h1;
    // Fall driven at slot fall_pos, seen one bit clock later, load after lead bit clocks
    word_pulse <= !(run && slot_pos >= fall_pos && slot_pos <= fall_pos + 3'h1);
    serial_word <= {serial_word[4:0], word_in[3'h5 - slot_pos]};
    last_channel_n <= !(last_in && slot_pos == 3'h5);
  end
endmodule : pcm_timing_model

/* File: testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic word_pulse, last_channel_n, msb_ref, msb_gnd, subtract_half_bit, add_half_bit;
  logic [5:0] serial_word, ladder_drive;
  logic [5:0] word_in = 6'h00;
  logic last_in = 1'b0;
  logic [2:0] lead = 3'h2;
  logic run = 1'b0;
  logic [2:0] slot_pos;
  logic [31:0] got, cnt0;
  logic [5:0] words [11] = '{6'h0f, 6'h30, 6'h00, 6'h3f, 6'h0e, 6'h2f, 6'h10, 6'h31,
    6'h3f, 6'h0f, 6'h01};
  logic [10:0] lasts = 11'h300;
  logic [3:0] dly [3] = '{4'h0, 4'h1, 4'h3};
  int num_errors = 0;
  int samples_checked = 0;

  // ********
  // Clocks and parts
  // ********
  always #20 clk = ~clk;
  // Link clock is offset so its edges drift against the system clock
  initial begin
    #17;
    forever begin
      #62 link_clk = 1'b1;
      #63 link_clk = 1'b0;
    end
  end

  pcm_word_parallel_stage dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .link_clk(link_clk),
    .word_pulse(word_pulse), .last_channel_n(last_channel_n), .serial_word(serial_word),
    .ladder_drive(ladder_drive), .msb_ref(msb_ref), .msb_gnd(msb_gnd),
    .subtract_half_bit(subtract_half_bit), .add_half_bit(add_half_bit));
  pcm_timing_model model (.link_clk(link_clk), .run(run), .word_in(word_in),
    .last_in(last_in), .lead(lead), .slot_pos(slot_pos), .word_pulse(word_pulse),
    .last_channel_n(last_channel_n), .serial_word(serial_word));

  // ********
  // Tasks
  // ********
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : reg_read

  task automatic next_slot;
    do @(negedge link_clk); while (slot_pos !== 3'h0);
  endtask : next_slot

  // Word is shifted through one slot, loaded at its end, then checked
  task automatic send_word(input logic [5:0] w, input logic l);
    logic [5:0] ex;
    logic sub_e, add_e;
    next_slot();
    word_in = w;
    last_in = l;
    next_slot();
    repeat (10) @(negedge clk);
    ex = l ? {w[5:1], 1'b0} : w;
    sub_e = (w == pcm_stage_pkg::CODE_SUBTRACT);
    add_e = (w != pcm_stage_pkg::CODE_ADD);
    check("ladder_drive", {26'h0, ex}, {26'h0, ladder_drive});
    check("msb_pair", {30'h0, w[5], ~w[5]}, {30'h0, msb_ref, msb_gnd});
    check("corr_bits", {30'h0, sub_e, add_e}, {30'h0, subtract_half_bit, add_half_bit});
    reg_read(pcm_stage_pkg::STATUS_ADDR, got);
    check("status", {24'h0, add_e, sub_e, ex}, got);
  endtask : send_word

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // ********
  // Sequence
  // ********
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    reg_read(pcm_stage_pkg::CTRL_ADDR, got);
    check("ctrl_reset", {24'h0, pcm_stage_pkg::DELAY_RESET, 4'h0}, got);
    reg_write(4'hc, 32'hffffffff);
    reg_read(4'hc, got);
    check("unmapped", 32'h0, got);
    reg_read(pcm_stage_pkg::COUNT_ADDR, got);
    check("count_reset", 32'h0, got);
    // Read data stand one cycle only, then fall back to zero
    @(negedge clk);
    check("rdata_idle", 32'h0, rdata);
    // A write while the clock enable is low must be ignored
    @(posedge clk);
    ce <= 1'b0;
    reg_write(pcm_stage_pkg::CTRL_ADDR, 32'h31);
    @(posedge clk);
    ce <= 1'b1;
    reg_read(pcm_stage_pkg::CTRL_ADDR, got);
    check("ctrl_frozen", {24'h0, pcm_stage_pkg::DELAY_RESET, 4'h0}, got);
    repeat (8) @(negedge link_clk);
    run = 1'b1;
    // Medium traffic: every code class, last channel included
    for (int i = 0; i < 11; i++) begin
      send_word(words[i], lasts[i]);
    end
    // Reads a fixed phase apart: six slots must give six transfers
    next_slot();
    repeat (3) @(negedge link_clk);
    reg_read(pcm_stage_pkg::COUNT_ADDR, cnt0);
    repeat (36) @(negedge link_clk);
    reg_read(pcm_stage_pkg::COUNT_ADDR, got);
    check("count_step", 32'h6, (got - cnt0) & 32'hffff);
    // High traffic: the pulse leads the load by two bit clocks plus the set delay; zero acts as one
    for (int k = 0; k < 3; k++) begin
      next_slot();
      lead = 3'h2 + ((dly[k] == 4'h0) ? 3'h1 : dly[k][2:0]);
      reg_write(pcm_stage_pkg::CTRL_ADDR, {24'h0, dly[k], 4'h1});
      reg_read(pcm_stage_pkg::CTRL_ADDR, got);
      check("ctrl", {24'h0, dly[k], 4'h1}, got);
      repeat (12) @(negedge link_clk);
      reg_write(pcm_stage_pkg::STATUS_ADDR, 32'h100);
      send_word(6'h0f, 1'b0);
      send_word(6'h30, 1'b0);
      send_word(6'h3f, 1'b1);
    end
    summarize();
  end

  // Watchdog: the sequence needs about 45 us, so 200 us means a hang
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
endmodule : testbench
